// >>> logic/sepfp_packer.v
// Notes on behaviour
// - A second daytime field is 4980 bits of 12-bit items ending at packet bit 5123.
// - The second daytime packet carries views 6 to 10 as 415 twelve-bit words.
// - The night field is 171 twelve-bit words, 2052 bits, with 12 fill bits after the last item.
// - With the fill, the night field ends at packet bit 2195.
// - Item positions are whole-packet bit numbers, not offsets into the field.
// - Night items start at bit 144, views 1 to 10, bands 20 to 36 ascending, det = view, sample 1.
// - The first engineering field carries 550 eight-bit restore offsets, 4400 bits.
// - Engineering word N starts at packet bit 144 + 8N, in ascending word order.
// - Each 55-word group holds bands 1-2 x4, 3-7 x2, 8-30 x1 with 13/14 split, 31-36 post/pre.
// - Detector indices advance per group by 4, 2 or 1 according to the band's detector count.
// - The first daytime packet carries views 1 to 5.

`include "sepfp_regs.vh"

module sepfp_packer (
  input  wire        i_clk,
  input  wire        i_resetn,
  input  wire        i_start,
  input  wire [1:0]  i_kind,
  input  wire        i_smp_valid,
  input  wire [11:0] i_smp_data,
  output reg         o_busy_q,
  output reg         o_done_q,
  output reg         o_req_valid_q,
  output reg  [1:0]  o_req_kind_q,
  output reg  [3:0]  o_req_view_q,
  output reg  [6:0]  o_req_item_q,
  output reg  [5:0]  o_req_band_q,
  output reg  [5:0]  o_req_det_q,
  output reg  [2:0]  o_req_sample_q,
  output reg         o_req_gain_high_q,
  output reg         o_req_preamp_q,
  output reg  [9:0]  o_req_word_q,
  output wire        o_bit_q,
  output wire        o_bit_valid_q,
  output wire [12:0] o_bit_pos_q,
  output wire        o_bit_last_q
);

  localparam [5:0] ST_IDLE = 6'b000001;
  localparam [5:0] ST_PREP = 6'b000010;
  localparam [5:0] ST_REQ  = 6'b000100;
  localparam [5:0] ST_SEND = 6'b001000;
  localparam [5:0] ST_FILL = 6'b010000;
  localparam [5:0] ST_WAIT = 6'b100000;

  reg  [5:0]  state_q;
  reg  [1:0]  kind_q;
  reg  [3:0]  view_q;
  reg  [6:0]  item_q;
  reg  [3:0]  group_q;
  reg  [5:0]  row_q;
  reg  [9:0]  word_q;
  reg  [12:0] pos_q;
  reg         ld_q;
  reg  [11:0] ld_data_q;
  reg  [3:0]  ld_width_q;
  reg  [12:0] ld_pos_q;
  reg         ld_last_q;

  wire [5:0]  eng_band;
  wire [5:0]  eng_det;
  wire        eng_gain_high;
  wire        eng_preamp;
  wire        ser_done;

  wire        is_eng   = (kind_q == `SEPFP_KIND_ENG);
  wire        is_night = (kind_q == `SEPFP_KIND_NIGHT);

  // Opening view of a science field; engineering ignores it
  function [3:0] first_view;
    input [1:0] kind;
    begin
      if (kind == `SEPFP_KIND_DAY2) begin
        first_view = `SEPFP_DAY2_FIRST_VIEW;
      end else begin
        first_view = `SEPFP_DAY1_FIRST_VIEW;
      end
    end
  endfunction

  // Next item start, one item width further along the packet
  function [12:0] step_pos;
    input [12:0] pos;
    input [3:0]  width;
    begin
      step_pos = pos + {9'h000, width};
    end
  endfunction

  function is_view_end;
    input [6:0] item;
    input [6:0] per;
    begin
      is_view_end = (item == per - 7'h01);
    end
  endfunction

  // Last item of the field for the packet kind in progress
  function last_item;
    input [1:0] kind;
    input [3:0] view;
    input [6:0] item;
    input [3:0] group;
    input [5:0] row;
    begin
      if (kind == `SEPFP_KIND_ENG) begin
        last_item = (group == `SEPFP_ENG_GROUPS - 4'h1) &&
                    (row == `SEPFP_ENG_GROUP_WORDS - 6'h01);
      end else if (kind == `SEPFP_KIND_NIGHT) begin
        last_item = (view == `SEPFP_NIGHT_VIEWS) &&
                    is_view_end(item, `SEPFP_NIGHT_ITEMS_VIEW);
      end else if (kind == `SEPFP_KIND_DAY2) begin
        last_item = (view == `SEPFP_DAY2_FIRST_VIEW + `SEPFP_DAY_VIEWS - 4'h1) &&
                    is_view_end(item, `SEPFP_DAY_ITEMS_VIEW);
      end else begin
        last_item = (view == `SEPFP_DAY1_FIRST_VIEW + `SEPFP_DAY_VIEWS - 4'h1) &&
                    is_view_end(item, `SEPFP_DAY_ITEMS_VIEW);
      end
    end
  endfunction

  wire at_last = last_item(kind_q, view_q, item_q, group_q, row_q);

  // Items per view depend on whether this is a day or night field
  function [6:0] items_per_view;
    input [1:0] kind;
    begin
      if (kind == `SEPFP_KIND_NIGHT) begin
        items_per_view = `SEPFP_NIGHT_ITEMS_VIEW;
      end else begin
        items_per_view = `SEPFP_DAY_ITEMS_VIEW;
      end
    end
  endfunction

  wire [6:0] items_view = items_per_view(kind_q);

  sepfp_eng_map u_map (
    .i_group     (group_q),
    .i_row       (row_q),
    .o_band      (eng_band),
    .o_det       (eng_det),
    .o_gain_high (eng_gain_high),
    .o_preamp    (eng_preamp)
  );

  sepfp_serializer u_ser (
    .i_clk         (i_clk),
    .i_resetn      (i_resetn),
    .i_load        (ld_q),
    .i_data        (ld_data_q),
    .i_width       (ld_width_q),
    .i_pos         (ld_pos_q),
    .i_last        (ld_last_q),
    .o_bit_q       (o_bit_q),
    .o_bit_valid_q (o_bit_valid_q),
    .o_bit_pos_q   (o_bit_pos_q),
    .o_bit_last_q  (o_bit_last_q),
    .o_done_q      (ser_done)
  );

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q           <= ST_IDLE;
      kind_q            <= `SEPFP_KIND_DAY1;
      view_q            <= 4'h0;
      item_q            <= 7'h00;
      group_q           <= 4'h0;
      row_q             <= 6'h00;
      word_q            <= 10'h000;
      pos_q             <= `SEPFP_FIELD_START;
      ld_q              <= 1'b0;
      ld_data_q         <= 12'h000;
      ld_width_q        <= 4'h0;
      ld_pos_q          <= 13'h0000;
      ld_last_q         <= 1'b0;
      o_busy_q          <= 1'b0;
      o_done_q          <= 1'b0;
      o_req_valid_q     <= 1'b0;
      o_req_kind_q      <= `SEPFP_KIND_DAY1;
      o_req_view_q      <= 4'h0;
      o_req_item_q      <= 7'h00;
      o_req_band_q      <= 6'h00;
      o_req_det_q       <= 6'h00;
      o_req_sample_q    <= 3'h0;
      o_req_gain_high_q <= 1'b0;
      o_req_preamp_q    <= 1'b0;
      o_req_word_q      <= 10'h000;
    end else begin
      ld_q     <= 1'b0;
      o_done_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (i_start) begin
            kind_q   <= i_kind;
            view_q   <= first_view(i_kind);
            item_q   <= 7'h00;
            group_q  <= 4'h0;
            row_q    <= 6'h00;
            word_q   <= 10'h000;
            pos_q    <= `SEPFP_FIELD_START;
            o_busy_q <= 1'b1;
            state_q  <= ST_PREP;
          end
        end

        ST_PREP: begin
          // Descriptor is built from settled counters so every request output is a flop
          o_req_valid_q     <= 1'b1;
          o_req_kind_q      <= kind_q;
          o_req_view_q      <= is_eng ? 4'h0 : view_q;
          o_req_item_q      <= is_eng ? 7'h00 : item_q;
          o_req_word_q      <= is_eng ? word_q : 10'h000;
          o_req_gain_high_q <= is_eng ? eng_gain_high : 1'b0;
          o_req_preamp_q    <= is_eng ? eng_preamp : 1'b0;
          if (is_eng) begin
            o_req_band_q   <= eng_band;
            o_req_det_q    <= eng_det;
            o_req_sample_q <= 3'h0;
          end else if (is_night) begin
            o_req_band_q   <= `SEPFP_NIGHT_BAND_FIRST + item_q[5:0];
            o_req_det_q    <= {2'b00, view_q};
            o_req_sample_q <= `SEPFP_NIGHT_SAMPLE;
          end else begin
            // Day items are named by view and slot; the source resolves band
            o_req_band_q   <= 6'h00;
            o_req_det_q    <= 6'h00;
            o_req_sample_q <= 3'h0;
          end
          state_q <= ST_REQ;
        end

        ST_REQ: begin
          if (i_smp_valid) begin
            o_req_valid_q <= 1'b0;
            ld_q          <= 1'b1;
            ld_pos_q      <= pos_q;
            if (is_eng) begin
              ld_data_q  <= {i_smp_data[7:0], 4'h0};
              ld_width_q <= `SEPFP_ENG_ITEM_BITS;
              pos_q      <= step_pos(pos_q, `SEPFP_ENG_ITEM_BITS);
            end else begin
              ld_data_q  <= i_smp_data;
              ld_width_q <= `SEPFP_SCI_ITEM_BITS;
              pos_q      <= step_pos(pos_q, `SEPFP_SCI_ITEM_BITS);
            end
            // Night field carries on into the fill, so its last bit is there
            ld_last_q <= at_last && !is_night;
            state_q   <= ST_SEND;
          end
        end

        ST_SEND: begin
          if (ser_done) begin
            if (at_last) begin
              if (is_night) begin
                ld_q       <= 1'b1;
                ld_data_q  <= `SEPFP_FILL_VALUE;
                ld_width_q <= `SEPFP_FILL_BITS;
                ld_pos_q   <= pos_q;
                ld_last_q  <= 1'b1;
                pos_q      <= step_pos(pos_q, `SEPFP_FILL_BITS);
                state_q    <= ST_FILL;
              end else begin
                o_busy_q <= 1'b0;
                o_done_q <= 1'b1;
                state_q  <= ST_IDLE;
              end
            end else begin
              if (is_eng) begin
                word_q <= word_q + 10'h001;
                if (row_q == `SEPFP_ENG_GROUP_WORDS - 6'h01) begin
                  row_q   <= 6'h00;
                  group_q <= group_q + 4'h1;
                end else begin
                  row_q <= row_q + 6'h01;
                end
              end else if (is_view_end(item_q, items_view)) begin
                item_q <= 7'h00;
                view_q <= view_q + 4'h1;
              end else begin
                item_q <= item_q + 7'h01;
              end
              state_q <= ST_PREP;
            end
          end
        end

        ST_FILL: begin
          // One idle cycle lets the serializer take the fill word
          state_q <= ST_WAIT;
        end

        ST_WAIT: begin
          if (ser_done) begin
            o_busy_q <= 1'b0;
            o_done_q <= 1'b1;
            state_q  <= ST_IDLE;
          end
        end

        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // sepfp_packer

// >>> logic/sepfp_regs.vh
`ifndef SEPFP_REGS_VH
`define SEPFP_REGS_VH

// Packet kinds selected at start
`define SEPFP_KIND_DAY1        2'h0
`define SEPFP_KIND_DAY2        2'h1
`define SEPFP_KIND_NIGHT       2'h2
`define SEPFP_KIND_ENG         2'h3

// Field geometry, all positions are whole-packet bit numbers
`define SEPFP_FIELD_START      13'h0090
`define SEPFP_SCI_ITEM_BITS    4'hc
`define SEPFP_ENG_ITEM_BITS    4'h8
`define SEPFP_FILL_BITS        4'hc
`define SEPFP_FILL_VALUE       12'h000

// Daytime science: 5 views of 83 items, 415 words in all
`define SEPFP_DAY_VIEWS        4'h5
`define SEPFP_DAY_ITEMS_VIEW   7'h53
`define SEPFP_DAY1_FIRST_VIEW  4'h1
`define SEPFP_DAY2_FIRST_VIEW  4'h6
`define SEPFP_DAY_LAST_BIT     13'h1403

// Night science: 10 views of bands 20..36, then one fill word
`define SEPFP_NIGHT_VIEWS      4'ha
`define SEPFP_NIGHT_ITEMS_VIEW 7'h11
`define SEPFP_NIGHT_BAND_FIRST 6'h14
`define SEPFP_NIGHT_SAMPLE     3'h1
`define SEPFP_NIGHT_LAST_BIT   13'h0893

// Engineering: 10 groups of 55 offset words, 550 words in all
`define SEPFP_ENG_GROUPS       4'ha
`define SEPFP_ENG_GROUP_WORDS  6'h37
`define SEPFP_ENG_LAST_BIT     13'h11bf

`endif

// >>> logic/sepfp_eng_map.v
`include "sepfp_regs.vh"

// Maps an engineering word (group, row in group) to band and detector
module sepfp_eng_map (
  input  wire [3:0] i_group,
  input  wire [5:0] i_row,
  output reg  [5:0] o_band,
  output reg  [5:0] o_det,
  output reg        o_gain_high,
  output reg        o_preamp
);

  reg [5:0] rel;

  always @* begin
    rel         = 6'h00;
    o_band      = 6'h00;
    o_det       = 6'h00;
    o_gain_high = 1'b0;
    o_preamp    = 1'b0;
    if (i_row < 6'h08) begin
      // Four-detector bands 1 and 2
      o_band = (i_row < 6'h04) ? 6'h01 : 6'h02;
      o_det  = {i_group, 2'b00} + {4'h0, i_row[1:0]} + 6'h01;
    end else if (i_row < 6'h12) begin
      // Two-detector bands 3..7
      rel    = i_row - 6'h08;
      o_band = 6'h03 + {1'b0, rel[5:1]};
      o_det  = {1'b0, i_group, 1'b0} + {5'h00, rel[0]} + 6'h01;
    end else if (i_row < 6'h2b) begin
      // Single-detector bands 8..30, with 13 and 14 split by gain
      rel   = i_row - 6'h12;
      o_det = {2'b00, i_group} + 6'h01;
      if (rel < 6'h05) begin
        o_band = 6'h08 + rel;
      end else if (rel < 6'h09) begin
        o_band      = (rel < 6'h07) ? 6'h0d : 6'h0e;
        o_gain_high = ~rel[0];
      end else begin
        o_band = 6'h0f + (rel - 6'h09);
      end
    end else begin
      // Bands 31..36, post-amplifier word before pre-amplifier word
      rel      = i_row - 6'h2b;
      o_band   = 6'h1f + {1'b0, rel[5:1]};
      o_preamp = rel[0];
      o_det    = {2'b00, i_group} + 6'h01;
    end
  end

endmodule // sepfp_eng_map

// >>> logic/sepfp_serializer.v
`include "sepfp_regs.vh"

// Shifts one left-aligned item out MSB first, tagging each bit with its packet position
module sepfp_serializer (
  input  wire        i_clk,
  input  wire        i_resetn,
  input  wire        i_load,
  input  wire [11:0] i_data,
  input  wire [3:0]  i_width,
  input  wire [12:0] i_pos,
  input  wire        i_last,
  output reg         o_bit_q,
  output reg         o_bit_valid_q,
  output reg  [12:0] o_bit_pos_q,
  output reg         o_bit_last_q,
  output reg         o_done_q
);

  reg [11:0] sh_q;
  reg [3:0]  cnt_q;
  reg [12:0] pos_q;
  reg        last_q;

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sh_q          <= 12'h000;
      cnt_q         <= 4'h0;
      pos_q         <= 13'h0000;
      last_q        <= 1'b0;
      o_bit_q       <= 1'b0;
      o_bit_valid_q <= 1'b0;
      o_bit_pos_q   <= 13'h0000;
      o_bit_last_q  <= 1'b0;
      o_done_q      <= 1'b0;
    end else begin
      o_bit_valid_q <= 1'b0;
      o_bit_last_q  <= 1'b0;
      o_done_q      <= 1'b0;
      if (i_load) begin
        sh_q   <= i_data;
        cnt_q  <= i_width;
        pos_q  <= i_pos;
        last_q <= i_last;
      end else if (cnt_q != 4'h0) begin
        o_bit_q       <= sh_q[11];
        o_bit_valid_q <= 1'b1;
        o_bit_pos_q   <= pos_q;
        pos_q         <= pos_q + 13'h0001;
        sh_q          <= {sh_q[10:0], 1'b0};
        cnt_q         <= cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          o_done_q     <= 1'b1;
          o_bit_last_q <= last_q;
        end
      end
    end
  end

endmodule // sepfp_serializer

// >>> tb/sepfp_properties.sv
module sepfp_properties (
  input wire        i_clk,
  input wire        i_resetn,
  input wire        i_start,
  input wire [1:0]  i_kind,
  input wire        i_smp_valid,
  input wire        o_busy_q,
  input wire        o_done_q,
  input wire        o_req_valid_q,
  input wire [1:0]  o_req_kind_q,
  input wire [3:0]  o_req_view_q,
  input wire [6:0]  o_req_item_q,
  input wire [5:0]  o_req_band_q,
  input wire [5:0]  o_req_det_q,
  input wire [2:0]  o_req_sample_q,
  input wire [9:0]  o_req_word_q,
  input wire        o_bit_q,
  input wire        o_bit_valid_q,
  input wire [12:0] o_bit_pos_q,
  input wire        o_bit_last_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  kind_q;
  logic        first_q;
  logic [12:0] pos_q;
  logic [9:0]  word_q;

  // Kind is latched at the accepted start, so a late start cannot retag a field
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      kind_q <= 2'h0;
      first_q <= 1'b0;
      pos_q <= 13'h0000;
      word_q <= 10'h000;
    end else begin
      if (i_start && !o_busy_q) kind_q <= i_kind;
      if (i_start && !o_busy_q) first_q <= 1'b1;
      else if (o_bit_valid_q) first_q <= 1'b0;
      if (o_bit_valid_q) pos_q <= o_bit_pos_q;
      if (o_req_valid_q && i_smp_valid) word_q <= o_req_word_q;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  first_bit_a: assert property (o_bit_valid_q && first_q |-> o_bit_pos_q == 13'h0090)
    else $error("first bit off 144");
  bit_step_a: assert property (o_bit_valid_q && !first_q |-> o_bit_pos_q == pos_q + 13'h0001)
    else $error("bit position gap");
  day_last_a: assert property (o_bit_last_q && kind_q < 2'h2 |-> o_bit_pos_q == 13'h1403)
    else $error("day last bit wrong");
  night_last_a: assert property (o_bit_last_q && kind_q == 2'h2 |-> o_bit_pos_q == 13'h0893)
    else $error("night last bit wrong");
  eng_last_a: assert property (o_bit_last_q && kind_q == 2'h3 |-> o_bit_pos_q == 13'h11bf)
    else $error("eng last bit wrong");
  fill_zero_a: assert property (o_bit_valid_q && kind_q == 2'h2 && o_bit_pos_q >= 13'h0888 |-> !o_bit_q)
    else $error("fill bit not zero");
  night_desc_a: assert property (o_req_valid_q && o_req_kind_q == 2'h2 |->
    o_req_band_q == 6'h14 + 6'(o_req_item_q) && o_req_det_q == 6'(o_req_view_q)
    && o_req_sample_q == 3'h1) else $error("night request wrong");
  eng_pos_a: assert property (o_bit_valid_q && kind_q == 2'h3 && o_bit_pos_q[2:0] == 3'h0
    |-> o_bit_pos_q == 13'h0090 + {word_q, 3'h0}) else $error("eng word misplaced");
  group_step_a: assert property (o_req_valid_q && o_req_kind_q == 2'h3 && o_req_word_q == 10'h037
    |-> o_req_band_q == 6'h01 && o_req_det_q == 6'h05) else $error("word 55 wrong");
  done_pulse_a: assert property ($rose(o_bit_last_q) |-> ##1 o_done_q && !o_busy_q)
    else $error("done not after last bit");

  cover property (o_bit_last_q && kind_q == 2'h1);
  cover property (o_bit_last_q && kind_q == 2'h2);
  cover property (o_bit_last_q && kind_q == 2'h3);
endmodule // sepfp_properties

bind sepfp_packer sepfp_properties u_props (.*);

// >>> tb/sepfp_src_model.sv
module sepfp_src_model (
  input  wire        i_clk,
  input  wire        i_resetn,
  input  wire        i_slow,
  input  wire        i_req_valid,
  input  wire        i_eng,
  input  wire [3:0]  i_view,
  input  wire [6:0]  i_item,
  input  wire [9:0]  i_word,
  output logic        o_valid,
  output logic [11:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q;

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_valid <= 1'b0;
      o_data <= 12'h000;
      wait_q <= 2'h0;
    end else if (i_req_valid && !o_valid && (!i_slow || wait_q == 2'h3)) begin
      o_valid <= 1'b1;
      // Top nibble set on eng words to show it is dropped
      o_data <= i_eng ? {4'ha, i_word[7:0] ^ {6'h00, i_word[9:8]}} : {i_view, i_item, 1'b1};
      wait_q <= 2'h0;
    end else begin
      o_valid <= 1'b0;
      // Idle data never keeps its last value
      o_data <= ~o_data;
      wait_q <= (i_req_valid && !o_valid) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule // sepfp_src_model

// >>> tb/sepfp_packer_tb.sv
module sepfp_packer_tb;
  timeunit 1ns;
  timeprecision 1ps;
`define SEPFP_CHECK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
  logic        i_clk, i_resetn, i_start, slow;
  logic [1:0]  i_kind, cur_kind;
  logic        i_smp_valid, o_busy_q, o_done_q, o_req_valid_q, o_req_gain_high_q;
  logic        o_req_preamp_q, o_bit_q, o_bit_valid_q, o_bit_last_q;
  logic [11:0] i_smp_data;
  logic [1:0]  o_req_kind_q;
  logic [3:0]  o_req_view_q;
  logic [6:0]  o_req_item_q;
  logic [5:0]  o_req_band_q, o_req_det_q;
  logic [2:0]  o_req_sample_q;
  logic [9:0]  o_req_word_q;
  logic [12:0] o_bit_pos_q, exp_pos, last_pos;
  int          miscompares, tests_run, req_idx, bit_cnt;

  sepfp_packer dut (.*);
  sepfp_src_model u_src (.i_clk(i_clk), .i_resetn(i_resetn), .i_slow(slow),
    .i_req_valid(o_req_valid_q), .i_eng(o_req_kind_q == 2'h3), .i_view(o_req_view_q),
    .i_item(o_req_item_q), .i_word(o_req_word_q), .o_valid(i_smp_valid), .o_data(i_smp_data));

  function automatic logic [39:0] exp_desc(input logic [1:0] k, input int n);
    int g, r, s, band, det, v, per;
    logic gain, pre;
    g = n / 55;
    r = n % 55;
    s = r - 18;
    det = g + 1;
    gain = 1'b0;
    pre = 1'b0;
    if (r < 8) begin
      band = 1 + r / 4;
      det = 4 * g + r % 4 + 1;
    end else if (r < 18) begin
      band = 3 + (r - 8) / 2;
      det = 2 * g + (r - 8) % 2 + 1;
    end else if (s < 5) band = 8 + s;
    else if (s < 9) begin
      band = 13 + (s - 5) / 2;
      gain = (s == 6 || s == 8);
    end else if (r < 43) band = 6 + s;
    else begin
      band = 31 + (r - 43) / 2;
      pre = (r - 43) % 2;
    end
    if (k == 2'h3) return {k, 11'h000, 6'(band), 6'(det), 3'h0, gain, pre, 10'(n)};
    per = (k == 2'h2) ? 17 : 83;
    v = ((k == 2'h1) ? 6 : 1) + n / per;
    if (k == 2'h2) return {k, 4'(v), 7'(n % per), 6'(20 + n % per), 6'(v), 3'h1, 12'h000};
    return {k, 4'(v), 7'(n % per), 27'h0};
  endfunction

  function automatic logic exp_bit(input logic [1:0] k, input logic [12:0] pos);
    int o, n, per;
    logic [11:0] d;
    o = pos - 144;
    n = (k == 2'h3) ? o / 8 : o / 12;
    per = (k == 2'h2) ? 17 : 83;
    if (k == 2'h3) d = {4'h0, 8'(n) ^ 8'(n / 256)};
    else d = {4'(((k == 2'h1) ? 6 : 1) + n / per), 7'(n % per), 1'b1};
    if (k == 2'h2 && n == 170) d = 12'h000;
    return (k == 2'h3) ? d[7 - o % 8] : d[11 - o % 12];
  endfunction

  always @(posedge i_clk) begin
    if (i_resetn && o_req_valid_q && i_smp_valid) begin
      `SEPFP_CHECK({o_req_kind_q, o_req_view_q, o_req_item_q, o_req_band_q, o_req_det_q, o_req_sample_q, o_req_gain_high_q, o_req_preamp_q, o_req_word_q}, exp_desc(cur_kind, req_idx))
      req_idx++;
    end
    if (i_resetn && o_bit_valid_q) begin
      `SEPFP_CHECK({o_bit_pos_q, o_bit_q, o_bit_last_q}, {exp_pos, exp_bit(cur_kind, exp_pos), exp_pos == last_pos})
      exp_pos++;
      bit_cnt++;
    end
  end

  task automatic start_field(input logic [1:0] k, input int bits, input logic sl);
    cur_kind = k;
    req_idx = 0;
    bit_cnt = 0;
    exp_pos = 13'h0090;
    last_pos = 13'(143 + bits);
    @(posedge i_clk);
    slow <= sl;
    i_kind <= k;
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
  endtask

  task automatic run_field(input logic [1:0] k, input int items, input int bits, input logic sl);
    int w;
    start_field(k, bits, sl);
    w = 0;
    while (o_done_q !== 1'b1 && w < 20000) begin
      @(posedge i_clk);
      #1;
      w++;
    end
    `SEPFP_CHECK({o_busy_q, req_idx, bit_cnt}, {1'b0, items, bits})
  endtask

  task automatic test_night();
    run_field(2'h2, 170, 2052, 1'b0);
  endtask

  task automatic test_eng();
    run_field(2'h3, 550, 4400, 1'b1);
  endtask

  task automatic test_day1();
    run_field(2'h0, 415, 4980, 1'b0);
  endtask

  // A start given mid-field must not disturb the running packet
  task automatic test_day2();
    fork
      run_field(2'h1, 415, 4980, 1'b1);
      begin
        repeat (300) @(posedge i_clk);
        i_kind <= 2'h2;
        i_start <= 1'b1;
        @(posedge i_clk);
        i_start <= 1'b0;
      end
    join
  endtask

  task automatic test_abort();
    start_field(2'h2, 2052, 1'b0);
    repeat (200) @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    run_field(2'h3, 550, 4400, 1'b0);
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  initial begin
    #1ms;
    miscompares++;
    final_report();
  end

  initial begin
    i_resetn = 1'b0;
    i_start = 1'b0;
    i_kind = 2'h0;
    slow = 1'b0;
    cur_kind = 2'h0;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    test_night();
    test_eng();
    test_day1();
    test_day2();
    test_abort();
    final_report();
  end
endmodule // sepfp_packer_tb
